/* hw/dcs_top.sv */
`timescale 1ns/100ps
module dcs_top
    import dcs_pkg::*;
#(
    parameter int C4 = CYC_4MS,
    parameter int C16 = CYC_16MS,
    parameter int C32 = CYC_32MS,
    parameter int C64 = CYC_64MS
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // measurements (asynchronous, from adc)
    input wire logic [14:0] vbus_mv,
    input wire logic [14:0] vbat_mv,
    input wire logic signed [9:0] die_c,
    input wire logic signed [9:0] batt_c,
    // converter control
    output logic discharge_on,
    output logic charge_on,
    output logic converter_on,
    output logic use_feedback_pin,
    output logic [14:0] vout_set_mv,
    output logic [13:0] ibus_lim_ma,
    output logic [13:0] ibat_lim_ma,
    output logic [1:0] battery_thermistor_bias
);
    initial begin
        if (C4 < 1 || C16 < 1 || C32 < 1 || C64 < 1)
            $error("dcs_top: debounce counts must be positive");
    end
    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] ctrl;
    logic [10:0] vout_code;
    logic [6:0] ibus_code, ibat_code, uv_code;
    logic [1:0] hys_code;
    logic [7:0] tsel;
    logic wr, rd_ok;
    assign pready = 1'b1;
    assign wr = psel & penable & pwrite;
    always_comb begin
        rd_ok = 1'b1;
        case (paddr)
            ADDR_CTRL, ADDR_VOUT, ADDR_ILIM, ADDR_UVLO, ADDR_TEMP, ADDR_STAT, ADDR_SETP: rd_ok = 1'b1;
            default: rd_ok = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~rd_ok;
    logic dis_en_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 8'h04;
            vout_code <= 11'h000;
            ibus_code <= 7'h00;
            ibat_code <= 7'h00;
            uv_code <= UV_RESET_CODE;
            hys_code <= 2'h0;
            tsel <= 8'h00;
        end else if (wr) begin
            case (paddr)
                ADDR_CTRL: ctrl <= pwdata[7:0];
                ADDR_VOUT: vout_code <= pwdata[10:0];
                ADDR_ILIM: begin
                    ibus_code <= pwdata[6:0];
                    ibat_code <= pwdata[14:8];
                end
                ADDR_UVLO: begin
                    uv_code <= pwdata[6:0];
                    hys_code <= pwdata[9:8];
                end
                ADDR_TEMP: tsel <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    logic dis_en, reg_mode, therm_en, chg_en;
    assign dis_en = ctrl[CTRL_DIS_EN];
    assign reg_mode = ctrl[CTRL_REG_MODE];
    assign therm_en = ctrl[CTRL_THERM_EN];
    assign chg_en = ctrl[CTRL_CHG_EN];
    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic [14:0] vbus_a, vbus_s, vbat_a, vbat_s;
    logic signed [9:0] die_a, die_s, bat_a, bat_s;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vbus_a <= 15'h0000;
            vbus_s <= 15'h0000;
            vbat_a <= 15'h0000;
            vbat_s <= 15'h0000;
            die_a <= 10'sh000;
            die_s <= 10'sh000;
            bat_a <= 10'sh000;
            bat_s <= 10'sh000;
        end else begin
            vbus_a <= vbus_mv;
            vbus_s <= vbus_a;
            vbat_a <= vbat_mv;
            vbat_s <= vbat_a;
            die_a <= die_c;
            die_s <= die_a;
            bat_a <= batt_c;
            bat_s <= bat_a;
        end
    end
    // ---------------------------------------------------------------
    // setpoints
    // ---------------------------------------------------------------
    logic [31:0] v_raw, ib_raw, uv_raw;
    logic [31:0] vset, uv_mv, uv_rel, ovp_mv, ovx_mv, olp_mv;
    always_comb begin
        v_raw = VOUT_BASE_MV + VOUT_STEP_MV * 32'(vout_code);
        vset = (v_raw > VOUT_MAX_MV) ? VOUT_MAX_MV : v_raw;
        ib_raw = IBAT_BASE_MA + IBAT_STEP_MA * 32'(ibat_code);
        uv_raw = UV_BASE_MV + UV_STEP_MV * 32'(uv_code);
        uv_mv = (uv_raw > UV_MAX_MV) ? UV_MAX_MV : uv_raw;
        uv_rel = uv_mv + HYS_BASE_MV + HYS_STEP_MV * 32'(hys_code);
        ovp_mv = reg_mode ? vset * OVP_PCT / 100 : OVP_FB_MV;
        ovx_mv = reg_mode ? vset * OVX_PCT / 100 : OVX_FB_MV;
        olp_mv = reg_mode ? vset * OLP_PCT / 100 : OLP_FB_MV;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vout_set_mv <= 15'h0000;
            ibus_lim_ma <= 14'h0000;
            ibat_lim_ma <= 14'h0000;
            use_feedback_pin <= 1'b1;
            battery_thermistor_bias <= 2'h0;
        end else begin
            vout_set_mv <= vset[14:0];
            use_feedback_pin <= ~reg_mode;
            ibus_lim_ma <= 14'(IBUS_BASE_MA + IBUS_STEP_MA * 32'(ibus_code));
            ibat_lim_ma <= (ib_raw > IBAT_MAX_MA) ? 14'(IBAT_MAX_MA) : ib_raw[13:0];
            battery_thermistor_bias <= ctrl[CTRL_BIAS_LSB +: 2];
        end
    end
    // ---------------------------------------------------------------
    // temperature limits
    // ---------------------------------------------------------------
    function automatic logic signed [9:0] pick(input logic [1:0] s, input int a, b, c, d);
        int r;
        r = (s == 2'd0) ? a : (s == 2'd1) ? b : (s == 2'd2) ? c : d;
        return 10'(r);
    endfunction
    logic signed [9:0] clo, chi, dlo, dhi, tsd;
    assign clo = pick(tsel[TSEL_CLO +: 2], 10, 5, 0, -5);
    assign chi = pick(tsel[TSEL_CHI +: 2], 40, 45, 50, 55);
    assign dlo = pick(tsel[TSEL_DLO +: 2], -20, -10, -5, 0);
    assign dhi = pick(tsel[TSEL_DHI +: 2], 50, 55, 60, 65);
    assign tsd = 10'(TSD_BASE_C + TSD_STEP_C * int'(ctrl[CTRL_TSD_LSB +: 2]));
    // ---------------------------------------------------------------
    // debounced supervisors: one counter each, reset when condition drops
    // ---------------------------------------------------------------
    logic f_die, f_ct, f_dt, f_ov, f_ol, f_sc, f_uv;
    logic [31:0] n_die, n_ct, n_dt, n_ov, n_ol, n_sc, n_uv;
    logic c_die, c_ct, c_dt, c_ov, c_ol, c_sc, c_uv;
    logic [31:0] l_die, l_ct, l_dt, l_ov, l_uv;
    always_comb begin
        // battery temperature comes in as converted degrees
        c_die = f_die ? (die_s <= tsd - 10'(TSD_HYS_C)) : (die_s >= tsd);
        c_ct = f_ct ? (bat_s >= clo + 10'(NTC_HYS_C) && bat_s <= chi - 10'(NTC_HYS_C))
                    : (bat_s < clo || bat_s > chi);
        c_dt = f_dt ? (bat_s >= dlo + 10'(NTC_HYS_C) && bat_s <= dhi - 10'(NTC_HYS_C))
                    : (bat_s < dlo || bat_s > dhi);
        c_ov = f_ov ? (32'(vbus_s) < ovx_mv) : (32'(vbus_s) > ovp_mv);
        c_ol = discharge_on && (32'(vbus_s) < olp_mv);
        c_sc = discharge_on && (32'(vbus_s) < SCP_MV);
        c_uv = f_uv ? (32'(vbat_s) > uv_rel) : (32'(vbat_s) < uv_mv);
        l_die = C16;
        l_ct = C16;
        l_dt = C16;
        l_ov = C16;
        l_uv = f_uv ? C64 : C32;
    end
    logic rearm;
    assign rearm = dis_en & ~dis_en_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {n_die, n_ct, n_dt, n_ov, n_ol, n_sc, n_uv} <= '0;
            {f_die, f_ct, f_dt, f_ov, f_ol, f_sc, f_uv} <= 7'h00;
            dis_en_q <= 1'b0;
        end else begin
            dis_en_q <= dis_en;
            n_die <= !c_die ? 32'h0 : (n_die > l_die ? 32'h0 : n_die + 32'h1);
            if (c_die && n_die > l_die) f_die <= ~f_die;
            n_ct <= !(c_ct && therm_en && chg_en) ? 32'h0 : (n_ct > l_ct ? 32'h0 : n_ct + 32'h1);
            if (!therm_en) f_ct <= 1'b0;
            else if (c_ct && chg_en && n_ct > l_ct) f_ct <= ~f_ct;
            n_dt <= !(c_dt && therm_en && dis_en) ? 32'h0 : (n_dt > l_dt ? 32'h0 : n_dt + 32'h1);
            if (!therm_en) f_dt <= 1'b0;
            else if (c_dt && dis_en && n_dt > l_dt) f_dt <= ~f_dt;
            n_ov <= !(c_ov && dis_en) ? 32'h0 : (n_ov > l_ov ? 32'h0 : n_ov + 32'h1);
            if (c_ov && dis_en && n_ov > l_ov) f_ov <= ~f_ov;
            n_uv <= !(c_uv && dis_en) ? 32'h0 : (n_uv > l_uv ? 32'h0 : n_uv + 32'h1);
            if (c_uv && dis_en && n_uv > l_uv) f_uv <= ~f_uv;
            // overload: 32 ms, latched; short: more than 4 ms, latched
            n_ol <= c_ol ? (n_ol >= 32'(C32) ? n_ol : n_ol + 32'h1) : 32'h0;
            n_sc <= c_sc ? (n_sc > 32'(C4) ? n_sc : n_sc + 32'h1) : 32'h0;
            if (c_ol && n_ol == 32'(C32) - 32'h1) f_ol <= 1'b1;
            else if (rearm) f_ol <= 1'b0;
            if (c_sc && n_sc == 32'(C4)) f_sc <= 1'b1;
            else if (rearm) f_sc <= 1'b0;
        end
    end
    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    logic next_dis, next_chg;
    assign next_dis = dis_en & ~f_die & ~f_dt & ~f_ov & ~f_ol & ~f_sc & ~f_uv;
    assign next_chg = chg_en & ~f_die & ~f_ct & ~dis_en;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            discharge_on <= 1'b0;
            charge_on <= 1'b0;
            converter_on <= 1'b0;
        end else begin
            discharge_on <= next_dis;
            charge_on <= next_chg;
            converter_on <= ~f_die & (next_dis | next_chg);
        end
    end
    logic [7:0] stat;
    assign stat = {discharge_on, f_uv, f_sc, f_ol, f_ov, f_dt, f_ct, f_die};
    always_comb begin
        case (paddr)
            ADDR_CTRL: prdata = {24'h000000, ctrl};
            ADDR_VOUT: prdata = {21'h000000, vout_code};
            ADDR_ILIM: prdata = {17'h00000, ibat_code, 1'b0, ibus_code};
            ADDR_UVLO: prdata = {22'h000000, hys_code, 1'b0, uv_code};
            ADDR_TEMP: prdata = {24'h000000, tsel};
            ADDR_STAT: prdata = {24'h000000, stat};
            ADDR_SETP: prdata = {17'h00000, vout_set_mv};
            default: prdata = 32'h00000000;
        endcase
    end
endmodule

/* inc/dcs_pkg.sv */
package dcs_pkg;
    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_VOUT = 8'h04;
    localparam logic [7:0] ADDR_ILIM = 8'h08;
    localparam logic [7:0] ADDR_UVLO = 8'h0C;
    localparam logic [7:0] ADDR_TEMP = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    localparam logic [7:0] ADDR_SETP = 8'h18;
    // ---------------------------------------------------------------
    // ctrl fields
    // ---------------------------------------------------------------
    localparam int CTRL_DIS_EN = 0;
    localparam int CTRL_REG_MODE = 1;
    localparam int CTRL_THERM_EN = 2;
    localparam int CTRL_CHG_EN = 3;
    localparam int CTRL_BIAS_LSB = 4;
    localparam int CTRL_TSD_LSB = 6;
    // ---------------------------------------------------------------
    // temp select fields
    // ---------------------------------------------------------------
    localparam int TSEL_CLO = 0;
    localparam int TSEL_CHI = 2;
    localparam int TSEL_DLO = 4;
    localparam int TSEL_DHI = 6;
    // ---------------------------------------------------------------
    // status bits
    // ---------------------------------------------------------------
    localparam int ST_DIE = 0;
    localparam int ST_CHG_T = 1;
    localparam int ST_DIS_T = 2;
    localparam int ST_OVP = 3;
    localparam int ST_OLP = 4;
    localparam int ST_SCP = 5;
    localparam int ST_UVP = 6;
    localparam int ST_RUN = 7;
    // ---------------------------------------------------------------
    // field scaling (millivolt / milliamp)
    // ---------------------------------------------------------------
    localparam int VOUT_BASE_MV = 3000;
    localparam int VOUT_STEP_MV = 10;
    localparam int VOUT_MAX_MV = 22000;
    localparam int IBUS_BASE_MA = 500;
    localparam int IBUS_STEP_MA = 50;
    localparam int IBAT_BASE_MA = 100;
    localparam int IBAT_STEP_MA = 100;
    localparam int IBAT_MAX_MA = 12000;
    localparam int UV_BASE_MV = 2500;
    localparam int UV_STEP_MV = 100;
    localparam int UV_MAX_MV = 13200;
    localparam logic [6:0] UV_RESET_CODE = 7'h05;
    localparam int HYS_BASE_MV = 400;
    localparam int HYS_STEP_MV = 100;
    localparam int OVP_FB_MV = 24000;
    localparam int OVX_FB_MV = 22740;
    localparam int OVP_PCT = 112;
    localparam int OVX_PCT = 106;
    localparam int OLP_FB_MV = 1760;
    localparam int OLP_PCT = 80;
    localparam int SCP_MV = 1760;
    // ---------------------------------------------------------------
    // temperatures (deg C)
    // ---------------------------------------------------------------
    localparam int TSD_BASE_C = 120;
    localparam int TSD_STEP_C = 10;
    localparam int TSD_HYS_C = 20;
    localparam int NTC_HYS_C = 5;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int T4_MS = 4;
    localparam int T16_MS = 16;
    localparam int T32_MS = 32;
    localparam int T64_MS = 64;
    localparam int CYC_4MS = CLK_HZ / 1000 * T4_MS;
    localparam int CYC_16MS = CLK_HZ / 1000 * T16_MS;
    localparam int CYC_32MS = CLK_HZ / 1000 * T32_MS;
    localparam int CYC_64MS = CLK_HZ / 1000 * T64_MS;
endpackage

/* bench/dcs_top_sva.sv */
`timescale 1ns/100ps
module dcs_top_sva
    import dcs_pkg::*;
#(
    parameter int C4 = 4,
    parameter int C16 = 16
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    // measurements
    input wire logic [14:0] vbus_mv,
    input wire logic signed [9:0] die_c,
    input wire logic signed [9:0] batt_c,
    // converter control
    input wire logic discharge_on,
    input wire logic converter_on,
    input wire logic use_feedback_pin,
    input wire logic [14:0] vout_set_mv,
    input wire logic [13:0] ibus_lim_ma,
    input wire logic [13:0] ibat_lim_ma
);
    // ----
    // run-length counters of fault conditions seen while discharging or while the converter is on
    // ----
    logic [15:0] n_sc;
    logic [15:0] n_dt;
    logic [15:0] n_hot;
    wire wc = psel && penable && pwrite && paddr == ADDR_CTRL;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) n_sc <= '0;
        else n_sc <= (discharge_on && vbus_mv < 15'd1760) ? n_sc + 16'h1 : '0;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) n_dt <= '0;
        else n_dt <= (discharge_on && batt_c < -10'sd20) ? n_dt + 16'h1 : '0;
    end
    // die at the top level is past every selectable trip point, so the converter must drop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) n_hot <= '0;
        else n_hot <= (converter_on && die_c >= 10'sd150) ? n_hot + 16'h1 : '0;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_vout; vout_set_mv <= 15'd22000 && (vout_set_mv == 15'd0 || vout_set_mv >= 15'd3000); endproperty
    a_vout: assert property (p_vout) else $error("setpoint out of range");
    property p_ibus; ibus_lim_ma <= 14'd6850 && ibus_lim_ma % 14'd50 == 14'd0; endproperty
    a_ibus: assert property (p_ibus) else $error("port limit off grid");
    property p_ibat; ibat_lim_ma <= 14'd12000 && ibat_lim_ma % 14'd100 == 14'd0; endproperty
    a_ibat: assert property (p_ibat) else $error("battery limit off grid");
    property p_mode; $changed(use_feedback_pin) |-> $past(wc) || $past(wc, 2); endproperty
    a_mode: assert property (p_mode) else $error("mode moved without ctrl write");
    property p_trip; n_hot <= C16 + 8; endproperty
    a_trip: assert property (p_trip) else $error("converter still on while die hot");
    property p_back; $rose(converter_on) |-> $past(die_c, 6) <= 10'sd130; endproperty
    a_back: assert property (p_back) else $error("converter back while die hot");
    property p_short; n_sc <= C4 + 8; endproperty
    a_short: assert property (p_short) else $error("short not acted on");
    property p_dtemp; n_dt <= C16 + 8; endproperty
    a_dtemp: assert property (p_dtemp) else $error("cold battery still discharging");
    c_dis: cover property ($rose(discharge_on));
    c_die: cover property ($fell(converter_on));
    c_err: cover property (pslverr);
endmodule

/* bench/dcs_host.sv */
`timescale 1ns/100ps
module dcs_host
    import dcs_pkg::*;
(
    // apb
    input wire logic pclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // ----
    // transfers; request held until pready is sampled high
    // ----
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        acc(1'b1, a, d, q, e);
    endtask
    // thermistor protection never turned off, so callers never need to set it either
    task ctl(input logic [31:0] d);
        wr(ADDR_CTRL, d | 32'h4);
    endtask
    task cfg(input logic [31:0] v, input logic [31:0] il, input logic [31:0] uv, input logic [31:0] c);
        wr(ADDR_VOUT, v);
        wr(ADDR_ILIM, il);
        wr(ADDR_UVLO, uv);
        ctl(c);
    endtask
endmodule

/* bench/dcs_top_test.sv */
`timescale 1ns/100ps
module dcs_top_test
    import dcs_pkg::*;
;
    localparam int C16 = 16;
    localparam logic [31:0] RG = 32'h6;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [14:0] vbus_mv, vbat_mv, vout_set_mv;
    logic signed [9:0] die_c, batt_c;
    logic discharge_on, charge_on, converter_on, use_feedback_pin;
    logic [13:0] ibus_lim_ma, ibat_lim_ma;
    logic [1:0] battery_thermistor_bias;
    int errors, compares;
    int vc [3] = '{0, 'h76B, 'h7FF};
    int vx [3] = '{3000, 21990, 22000};
    int ic [3] = '{0, 'h7776, 'h7F7F};
    int bx [3] = '{500, 6400, 6850};
    int tx [3] = '{100, 12000, 12000};
    int lim [16] = '{10, 5, 0, -5, 40, 45, 50, 55, -20, -10, -5, 0, 50, 55, 60, 65};
    dcs_top #(.C4(4), .C16(C16), .C32(32), .C64(64)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .vbus_mv(vbus_mv), .vbat_mv(vbat_mv), .die_c(die_c), .batt_c(batt_c),
        .discharge_on(discharge_on), .charge_on(charge_on), .converter_on(converter_on),
        .use_feedback_pin(use_feedback_pin), .vout_set_mv(vout_set_mv), .ibus_lim_ma(ibus_lim_ma),
        .ibat_lim_ma(ibat_lim_ma), .battery_thermistor_bias(battery_thermistor_bias));
    dcs_host host_u (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ----
    // helpers
    // ----
    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            errors++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, g, x);
        end
    endtask
    task rd(input logic [7:0] a);
        host_u.acc(1'b0, a, 32'h0, q, e);
    endtask
    task rearm;
        host_u.ctl(RG);
        host_u.ctl(RG | 32'h1);
        wt(4);
    endtask
    task ov(input logic [14:0] hi, input logic [14:0] lo);
        vbus_mv <= hi;
        wt(C16 + 10);
        chk(discharge_on, 1'b0);
        rd(ADDR_STAT);
        chk(q[ST_OVP], 1'b1);
        vbus_mv <= lo;
        wt(C16 + 10);
        chk(discharge_on, 1'b1);
        vbus_mv <= 15'd5000;
    endtask
    task close_out;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        wt(10000);
        errors++;
        close_out();
    end
    initial begin
        errors = 0;
        compares = 0;
        presetn = 1'b0;
        vbus_mv = 15'd5000;
        vbat_mv = 15'd12000;
        die_c = 10'sd25;
        batt_c = 10'sd25;
        wt(12);
        presetn <= 1'b1;
        rd(ADDR_CTRL);
        chk(q, 32'h4);
        rd(ADDR_UVLO);
        chk(q & 32'h7F, 32'h5);
        chk(use_feedback_pin, 1'b1);
        chk(pready, 1'b1);
        rd(8'h1C);
        chk(e, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            host_u.wr(ADDR_VOUT, vc[i]);
            host_u.wr(ADDR_ILIM, ic[i]);
            wt(2);
            chk(vout_set_mv, vx[i]);
            chk(ibus_lim_ma, bx[i]);
            chk(ibat_lim_ma, tx[i]);
        end
        rd(ADDR_SETP);
        chk(q, 32'd22000);
        $display("test scaling done");
        host_u.cfg(32'd200, 32'h0A0A, 32'h104, RG | 32'h1);
        wt(4);
        chk(discharge_on, 1'b1);
        chk(use_feedback_pin, 1'b0);
        ov(15'd5601, 15'd5299);
        host_u.ctl(32'h1);
        wt(4);
        chk(use_feedback_pin, 1'b1);
        ov(15'd24001, 15'd22739);
        host_u.ctl(RG | 32'h1);
        vbus_mv <= 15'd3999;
        wt(42);
        chk(discharge_on, 1'b0);
        vbus_mv <= 15'd5000;
        wt(C16 + 10);
        chk(discharge_on, 1'b0);
        rearm();
        chk(discharge_on, 1'b1);
        vbus_mv <= 15'd1759;
        wt(14);
        rd(ADDR_STAT);
        chk(q[ST_SCP], 1'b1);
        vbus_mv <= 15'd5000;
        rearm();
        $display("test rail done");
        vbat_mv <= 15'd2800;
        wt(42);
        chk(discharge_on, 1'b0);
        vbat_mv <= 15'd3300;
        wt(74);
        chk(discharge_on, 1'b0);
        vbat_mv <= 15'd3500;
        wt(74);
        chk(discharge_on, 1'b1);
        $display("test battery done");
        host_u.ctl(RG | 32'h41);
        die_c <= 10'sd129;
        wt(C16 + 10);
        chk(converter_on, 1'b1);
        die_c <= 10'sd130;
        wt(C16 + 10);
        chk(converter_on, 1'b0);
        die_c <= 10'sd111;
        wt(C16 + 10);
        chk(converter_on, 1'b0);
        die_c <= 10'sd110;
        wt(C16 + 10);
        chk(converter_on, 1'b1);
        die_c <= 10'sd25;
        for (int i = 0; i < 3; i++) begin
            host_u.ctl(RG | 32'h1 | (i << CTRL_BIAS_LSB));
            wt(2);
            chk(battery_thermistor_bias, i);
        end
        $display("test die done");
        for (int f = 0; f < 4; f++) begin
            batt_c <= 10'sd25;
            host_u.wr(ADDR_TEMP, 32'h0);
            host_u.ctl(f < 2 ? (RG | 32'h8) : (RG | 32'h1));
            wt(C16 + 10);
            for (int i = 0; i < 4; i++) begin
                host_u.wr(ADDR_TEMP, i << (2 * f));
                batt_c <= 10'(f % 2 == 0 ? lim[4 * f + i] - 1 : lim[4 * f + i] + 1);
                wt(C16 + 10);
                chk(f < 2 ? charge_on : discharge_on, 1'b0);
                batt_c <= 10'(f % 2 == 0 ? lim[4 * f + i] + 6 : lim[4 * f + i] - 6);
                wt(C16 + 10);
                chk(f < 2 ? charge_on : discharge_on, 1'b1);
            end
        end
        $display("test thermistor done");
        close_out();
    end
endmodule
bind dcs_top dcs_top_sva #(.C4(C4), .C16(C16)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr), .vbus_mv(vbus_mv), .die_c(die_c),
    .batt_c(batt_c), .discharge_on(discharge_on), .converter_on(converter_on),
    .use_feedback_pin(use_feedback_pin), .vout_set_mv(vout_set_mv), .ibus_lim_ma(ibus_lim_ma),
    .ibat_lim_ma(ibat_lim_ma));
